/* hdl/iepr_cfg.svh */
// register offsets, writable masks, reset values and field positions
// assumes: included by the top design file of the iepr block and by the bench top
`ifndef IEPR_CFG_SVH
`define IEPR_CFG_SVH

// ------------------------------------------------------------
// register byte offsets (aligned words on the bus)
// ------------------------------------------------------------
`define IEPR_OFS_EN3 12'h000
`define IEPR_OFS_EN4 12'h004
`define IEPR_OFS_EN5 12'h008
`define IEPR_OFS_PR0 12'h00C
`define IEPR_OFS_PR1 12'h010
`define IEPR_OFS_PEND 12'h014

// ------------------------------------------------------------
// implemented-bit masks and reset values
// ------------------------------------------------------------
`define IEPR_MASK_EN3 16'h4066
`define IEPR_MASK_EN4 16'h210E
`define IEPR_MASK_EN5 16'h3FFE
`define IEPR_MASK_PR0 16'h7777
`define IEPR_MASK_PR1 16'h7770
`define IEPR_RST_EN 16'h0000
`define IEPR_RST_PR0 16'h4444
`define IEPR_RST_PR1 16'h4440

// ------------------------------------------------------------
// priority field positions (low bit of each 3-bit field)
// ------------------------------------------------------------
`define IEPR_FLD_HI 12
`define IEPR_FLD_MH 8
`define IEPR_FLD_ML 4
`define IEPR_FLD_LO 0

// ------------------------------------------------------------
// enable bit positions
// ------------------------------------------------------------
`define IEPR_BIT_CALENDAR 14
`define IEPR_BIT_EXT4 6
`define IEPR_BIT_EXT3 5
`define IEPR_BIT_I2C2_M 2
`define IEPR_BIT_I2C2_S 1
`define IEPR_BIT_CHARGE 13
`define IEPR_BIT_LOWVOLT 8
`define IEPR_BIT_CHECKSUM 3
`define IEPR_BIT_UART2_ERR 2
`define IEPR_BIT_UART1_ERR 1

`endif

/* hdl/iepr_pkg.sv */
// types shared by the enable/priority register block
// assumes: nothing beyond a SystemVerilog compiler
package iepr_pkg;

   // ------------------------------------------------------------
   // bus phase capture
   // ------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
   } iepr_req_t;

   // request tagged with level toward the core
   typedef struct packed {
      logic       req;
      logic [2:0] level;
   } iepr_tag_t;

   typedef enum logic [1:0] {
      IEPR_ST_IDLE,
      IEPR_ST_WRITE
   } iepr_state_t;

endpackage : iepr_pkg

/* hdl/iepr_gate.sv */
// gate for one prioritised source: enable and level decide the request
// assumes: synchronous inputs on the same clock as the register block
`timescale 1ns/1ps
`default_nettype none

module iepr_gate (
   input wire logic i_pend,              // raw pending from peripheral
   input wire logic i_en,                // enable bit
   input wire logic [2:0] i_level,       // priority field
   output var iepr_pkg::iepr_tag_t o_tag // gated request with level
);

   // ------------------------------------------------------------
   // a zero level blocks whatever the enable says
   // ------------------------------------------------------------
   always_comb begin
      o_tag.req = i_pend && i_en && (i_level != 3'h0);
      o_tag.level = o_tag.req ? i_level : 3'h0;
   end

endmodule : iepr_gate

`default_nettype wire

/* hdl/iepr_top.sv */
// enable and priority registers with AHB-Lite slave and request gating
// assumes: one 40 MHz clock, single-word AHB-Lite transfers, sync inputs
// What this block does
// - enable one passes request, zero blocks
// - field 111 means level seven, highest
// - field 001 is level one, linear up
// - field 000 disables source regardless of enable
// - unimplemented bits read zero, ignore writes
// - reset clears enables, priority fields load 100
// - priority reg 0: timer1, compare1, capture1, ext0
// - priority reg 1: timer2, compare2, capture2 only
// - enable reg 3 bit placement fixed
// - enable reg 4 bit placement fixed
// - enable reg 5 bit placement fixed
`timescale 1ns/1ps
`default_nettype none
`include "iepr_cfg.svh"

module iepr_top (
   input wire logic i_ref_clk,           // 40 MHz clock
   input wire logic i_rstn,              // async reset, active low
   input wire logic i_hsel,              // slave select
   input wire logic [31:0] i_haddr,      // byte address
   input wire logic [1:0] i_htrans,      // transfer type
   input wire logic i_hwrite,            // write when high
   input wire logic [2:0] i_hsize,       // transfer size
   input wire logic [31:0] i_hwdata,     // write data
   input wire logic i_hready,            // bus ready in
   output logic [31:0] o_hrdata,         // read data
   output logic o_hreadyout,             // slave ready
   output logic o_hresp,                 // always okay
   input wire logic [3:0] i_prio_pend,   // pending: ext0,cap1,cmp1,tmr1,
   input wire logic [2:0] i_prio2_pend,  // pending: cap2,cmp2,tmr2
   input wire logic [15:0] i_en3_pend,   // pending at enable-3 positions
   input wire logic [15:0] i_en4_pend,   // pending at enable-4 positions
   input wire logic [15:0] i_en5_pend,   // pending at enable-5 positions
   output logic [15:0] o_en3_req,        // gated requests, enable-3 sources
   output logic [15:0] o_en4_req,        // gated requests, enable-4 sources
   output logic [15:0] o_en5_req,        // gated requests, enable-5 sources
   output logic [6:0] o_prio_req,        // tagged requests, prioritised srcs
   output logic [20:0] o_prio_level      // 3-bit levels, same order
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [15:0] en3_q;
   logic [15:0] en4_q;
   logic [15:0] en5_q;
   logic [15:0] pr0_q;
   logic [15:0] pr1_q;
   iepr_pkg::iepr_req_t req_q;
   iepr_pkg::iepr_req_t req_d;
   iepr_pkg::iepr_state_t st_q;
   iepr_pkg::iepr_tag_t tags [7];
   logic [6:0] pend_all;
   logic [20:0] lvl_all;
   logic [6:0] en_all;

   // field extraction used by several places
   function automatic logic [2:0] fld(input logic [15:0] r, input int lo);
      fld = r[lo +: 3];
   endfunction : fld

   // write merge keeps unimplemented bits at zero
   function automatic logic [15:0] merge(input logic [31:0] wd, input logic [15:0] m);
      merge = wd[15:0] & m;
   endfunction : merge

   // ------------------------------------------------------------
   // address phase capture
   // ------------------------------------------------------------
   always_comb begin
      req_d.valid = i_hsel && i_hready && i_htrans[1];
      req_d.write = i_hwrite;
      req_d.addr = i_haddr[11:0];
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // phase tracker: data phase of a write is pending
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= iepr_pkg::IEPR_ST_IDLE;
      end else begin
         case (st_q)
            iepr_pkg::IEPR_ST_IDLE: begin
               if (req_d.valid && req_d.write) begin
                  st_q <= iepr_pkg::IEPR_ST_WRITE;
               end
            end
            iepr_pkg::IEPR_ST_WRITE: begin
               if (!(req_d.valid && req_d.write)) begin
                  st_q <= iepr_pkg::IEPR_ST_IDLE;
               end
            end
            default: begin
               st_q <= iepr_pkg::IEPR_ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // register writes in the data phase
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         en3_q <= `IEPR_RST_EN;
         en4_q <= `IEPR_RST_EN;
         en5_q <= `IEPR_RST_EN;
         pr0_q <= `IEPR_RST_PR0;
         pr1_q <= `IEPR_RST_PR1;
      end else if (st_q == iepr_pkg::IEPR_ST_WRITE) begin
         case (req_q.addr)
            `IEPR_OFS_EN3: en3_q <= merge(i_hwdata, `IEPR_MASK_EN3);
            `IEPR_OFS_EN4: en4_q <= merge(i_hwdata, `IEPR_MASK_EN4);
            `IEPR_OFS_EN5: en5_q <= merge(i_hwdata, `IEPR_MASK_EN5);
            `IEPR_OFS_PR0: pr0_q <= merge(i_hwdata, `IEPR_MASK_PR0);
            `IEPR_OFS_PR1: pr1_q <= merge(i_hwdata, `IEPR_MASK_PR1);
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // read data registered at the address phase; always zero-wait
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hrdata <= 32'h00000000;
      end else if (req_d.valid && !req_d.write) begin
         case (req_d.addr)
            `IEPR_OFS_EN3: o_hrdata <= {16'h0000, en3_q};
            `IEPR_OFS_EN4: o_hrdata <= {16'h0000, en4_q};
            `IEPR_OFS_EN5: o_hrdata <= {16'h0000, en5_q};
            `IEPR_OFS_PR0: o_hrdata <= {16'h0000, pr0_q};
            `IEPR_OFS_PR1: o_hrdata <= {16'h0000, pr1_q};
            `IEPR_OFS_PEND: o_hrdata <= {25'h0000000, o_prio_req};
            default: o_hrdata <= 32'h00000000;
         endcase
      end
   end

   // zero wait states keep the slave simple; the cost is that a read whose
   // address phase meets the data phase of a write to the same word still
   // returns the old word, so masters leave one idle cycle in between
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // prioritised sources: tmr1,cmp1,cap1,ext0,tmr2,cmp2,cap2
   // no enable bits for these live here, so treat as enabled
   // ------------------------------------------------------------
   always_comb begin
      pend_all = {i_prio2_pend, i_prio_pend};
      en_all = 7'h7F;
      lvl_all = {fld(pr1_q, `IEPR_FLD_ML), fld(pr1_q, `IEPR_FLD_MH),
                 fld(pr1_q, `IEPR_FLD_HI), fld(pr0_q, `IEPR_FLD_LO),
                 fld(pr0_q, `IEPR_FLD_ML), fld(pr0_q, `IEPR_FLD_MH),
                 fld(pr0_q, `IEPR_FLD_HI)};
   end

   for (genvar g = 0; g < 7; g++) begin : g_gate
      iepr_gate u_gate (
         .i_pend(pend_all[g]),
         .i_en(en_all[g]),
         .i_level(lvl_all[g*3 +: 3]),
         .o_tag(tags[g])
      );
   end

   // registered outputs toward the core
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_prio_req <= 7'h00;
         o_prio_level <= 21'h000000;
      end else begin
         for (int k = 0; k < 7; k++) begin
            o_prio_req[k] <= tags[k].req;
            o_prio_level[k*3 +: 3] <= tags[k].level;
         end
      end
   end

   // enable-only sources; enable zero blocks the request
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_en3_req <= 16'h0000;
         o_en4_req <= 16'h0000;
         o_en5_req <= 16'h0000;
      end else begin
         o_en3_req <= i_en3_pend & en3_q;
         o_en4_req <= i_en4_pend & en4_q;
         o_en5_req <= i_en5_pend & en5_q;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_en_gate;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      1'b1 |=> (o_en3_req == ($past(i_en3_pend) & $past(en3_q)));
   endproperty
   a_en_gate: assert property (p_en_gate) else $error("enable-3 gating wrong");

   property p_en5_gate;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_en5_pend[6] && !en5_q[6]) |=> !o_en5_req[6];
   endproperty
   a_en5_gate: assert property (p_en5_gate) else $error("disabled source passed");

   property p_lvl7;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_prio_pend[0] && pr0_q[14:12] == 3'h7) |=> (o_prio_req[0] && o_prio_level[2:0] == 3'h7);
   endproperty
   a_lvl7: assert property (p_lvl7) else $error("level seven not forwarded");

   property p_lvl1;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_prio2_pend[2] && pr1_q[6:4] == 3'h1) |=> (o_prio_level[20:18] == 3'h1);
   endproperty
   a_lvl1: assert property (p_lvl1) else $error("level one not forwarded");

   property p_zero_off;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (pr0_q[2:0] == 3'h0) |=> !o_prio_req[3];
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("zero level forwarded");

   property p_unimpl;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      ((en3_q & ~`IEPR_MASK_EN3) == 16'h0000) && ((pr1_q & ~`IEPR_MASK_PR1) == 16'h0000)
      && ((en5_q & ~`IEPR_MASK_EN5) == 16'h0000) && ((pr0_q & ~`IEPR_MASK_PR0) == 16'h0000)
      && ((en4_q & ~`IEPR_MASK_EN4) == 16'h0000);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

   property p_rst_val;
      @(posedge i_ref_clk)
      $rose(i_rstn) |-> (pr0_q == `IEPR_RST_PR0 && pr1_q == `IEPR_RST_PR1 && en4_q == 16'h0000);
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset values wrong");

   property p_wr_pr0;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (req_q.valid && req_q.write && req_q.addr == `IEPR_OFS_PR0)
      |=> (pr0_q == ($past(i_hwdata[15:0]) & `IEPR_MASK_PR0));
   endproperty
   a_wr_pr0: assert property (p_wr_pr0) else $error("priority-0 write wrong");

   property p_rd_en4;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (req_d.valid && !req_d.write && req_d.addr == `IEPR_OFS_EN4)
      |=> (o_hrdata == {16'h0000, $past(en4_q)}) && o_hreadyout;
   endproperty
   a_rd_en4: assert property (p_rd_en4) else $error("enable-4 read wrong");

   // registers move only in a write data phase; a stray update would be silent
   property p_hold;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (st_q != iepr_pkg::IEPR_ST_WRITE) |=> ($stable(pr1_q) && $stable(en5_q));
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without a write");

   property p_lvl_mid;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_prio2_pend[0] && pr1_q[14:12] != 3'h0)
      |=> (o_prio_req[4] && o_prio_level[14:12] == $past(pr1_q[14:12]));
   endproperty
   a_lvl_mid: assert property (p_lvl_mid) else $error("middle level not forwarded");

   property p_idle_level;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (o_prio_req[1] == 1'b0) |-> (o_prio_level[5:3] == 3'h0);
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("level without request");

   c_write: cover property (@(posedge i_ref_clk) req_q.valid && req_q.write);
   c_read: cover property (@(posedge i_ref_clk) req_q.valid && !req_q.write);
   c_tag7: cover property (@(posedge i_ref_clk) o_prio_req[0] && o_prio_level[2:0] == 3'h7);
   c_block: cover property (@(posedge i_ref_clk) i_en5_pend[1] && !o_en5_req[1]);
   c_zero_lvl: cover property (@(posedge i_ref_clk) i_prio_pend[3] && pr0_q[2:0] == 3'h0);

endmodule : iepr_top

`default_nettype wire

/* hdl/unused_placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/iepr_partner.sv */
// peripheral event sources feeding the enable/priority block
// assumes: bench sets the pattern on the 40 MHz clock, sources hold level flags
`timescale 1ns/1ps
`default_nettype none

module iepr_partner (
   input wire logic i_ref_clk,         // 40 MHz clock
   input wire logic i_rstn,            // async reset, active low
   input wire logic [15:0] i_pattern,  // pending pattern wanted by the bench
   output logic [3:0] o_prio_pend,     // timer1, compare1, capture1, ext0
   output logic [2:0] o_prio2_pend,    // timer2, compare2, capture2
   output logic [15:0] o_en3_pend,     // sources behind enable 3
   output logic [15:0] o_en4_pend,     // sources behind enable 4
   output logic [15:0] o_en5_pend      // sources behind enable 5
);
   // ------------------------------------------------------------
   // source flags
   // ------------------------------------------------------------
   // flags move only on the clock edge so the block sees clean levels;
   // external sources are taken as already routed to a pin
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_prio_pend <= 4'h0;
         o_prio2_pend <= 3'h0;
         o_en3_pend <= 16'h0;
         o_en4_pend <= 16'h0;
         o_en5_pend <= 16'h0;
      end else begin
         o_prio_pend <= i_pattern[3:0];
         o_prio2_pend <= i_pattern[6:4];
         o_en3_pend <= i_pattern;
         o_en4_pend <= i_pattern;
         o_en5_pend <= i_pattern;
      end
   end
endmodule : iepr_partner

`default_nettype wire

/* tb/irq_enable_priority_regs_tb_top.sv */
// self-checking bench for the enable/priority register block
// assumes: one AHB-Lite master here, sources from iepr_partner
`timescale 1ns/1ps
`default_nettype none
`include "iepr_cfg.svh"

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end

module irq_enable_priority_regs_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] pattern = 16'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp;
   logic [3:0] prio_pend;
   logic [2:0] prio2_pend;
   logic [15:0] en3_pend, en4_pend, en5_pend, en3_req, en4_req, en5_req;
   logic [6:0] prio_req, exp_req;
   logic [20:0] prio_level, exp_lvl;
   logic [2:0] cd [7];
   logic [11:0] ofs [5] = '{`IEPR_OFS_EN3, `IEPR_OFS_EN4, `IEPR_OFS_EN5,
                            `IEPR_OFS_PR0, `IEPR_OFS_PR1};
   logic [15:0] msk [5] = '{`IEPR_MASK_EN3, `IEPR_MASK_EN4, `IEPR_MASK_EN5,
                            `IEPR_MASK_PR0, `IEPR_MASK_PR1};
   int miscompares = 0;
   int compares = 0;

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   iepr_top u_dut (.i_ref_clk(ref_clk), .i_rstn(rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .i_prio_pend(prio_pend), .i_prio2_pend(prio2_pend), .i_en3_pend(en3_pend),
      .i_en4_pend(en4_pend), .i_en5_pend(en5_pend), .o_en3_req(en3_req),
      .o_en4_req(en4_req), .o_en5_req(en5_req), .o_prio_req(prio_req),
      .o_prio_level(prio_level));

   iepr_partner u_src (.i_ref_clk(ref_clk), .i_rstn(rst_n), .i_pattern(pattern),
      .o_prio_pend(prio_pend), .o_prio2_pend(prio2_pend), .o_en3_pend(en3_pend),
      .o_en4_pend(en4_pend), .o_en5_pend(en5_pend));

   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   // address phase held until ready, then data phase held until ready
   task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus_xfer

   task automatic check_reg(input logic [11:0] a, input logic [31:0] exp);
      bus_xfer(1'b0, a, 32'h0);
      `CHK(rd, exp)
      `CHK(hresp, 1'b0)
   endtask : check_reg

   // outputs follow a write two edges later; sample away from the edge
   task automatic settle();
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle

   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         check_reg(ofs[i], 32'h0);
      end
      check_reg(`IEPR_OFS_PR0, 32'h4444);
      check_reg(`IEPR_OFS_PR1, 32'h4440);
      check_reg(12'h018, 32'h0);
      $display("test reset_values done");
      // all ones written: only implemented bits may stick
      for (int i = 0; i < 5; i++) begin
         bus_xfer(1'b1, ofs[i], 32'hFFFF_FFFF);
         check_reg(ofs[i], {16'h0, msk[i]});
      end
      $display("test masks done");
      // gating with enables set, two source patterns, then cleared
      foreach (msk[p]) begin
         if (p < 2) begin
            pattern <= (p == 0) ? 16'hFFFF : 16'h5555;
            settle();
            `CHK(en3_req, 16'h4066 & pattern)
            `CHK(en4_req, 16'h210E & pattern)
            `CHK(en5_req, 16'h3FFE & pattern)
         end
      end
      for (int i = 0; i < 3; i++) begin
         bus_xfer(1'b1, ofs[i], 32'h0);
      end
      settle();
      `CHK({en3_req, en4_req, en5_req}, 48'h0)
      $display("test enable_gating done");
      // every code in every field, each field a different code
      pattern <= 16'hFFFF;
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 7; k++) begin
            cd[k] = 3'(c + k);
            exp_req[k] = (cd[k] != 3'h0);
            exp_lvl[k*3 +: 3] = cd[k];
         end
         bus_xfer(1'b1, `IEPR_OFS_PR0,
            {17'h0, cd[0], 1'b0, cd[1], 1'b0, cd[2], 1'b0, cd[3]});
         bus_xfer(1'b1, `IEPR_OFS_PR1, {17'h0, cd[4], 1'b0, cd[5], 1'b0, cd[6], 4'h0});
         settle();
         `CHK(prio_req, exp_req)
         `CHK(prio_level, exp_lvl)
         check_reg(`IEPR_OFS_PEND, {25'h0, exp_req});
      end
      pattern <= 16'h0;
      settle();
      `CHK({prio_req, prio_level}, 28'h0)
      $display("test priority_levels done");
      // second reset in mid-run restores the defaults; enable 5 set first
      bus_xfer(1'b1, `IEPR_OFS_EN5, 32'hFFFF_FFFF);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      check_reg(`IEPR_OFS_PR1, 32'h4440);
      check_reg(`IEPR_OFS_PR0, 32'h4444);
      check_reg(`IEPR_OFS_EN5, 32'h0);
      $display("test second_reset done");
      report_and_stop();
   end

   // watchdog: the tests need well under a thousand cycles
   initial begin
      #100000;
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule : irq_enable_priority_regs_tb_top

`default_nettype wire
